// File: rtl/mic_irq_ctrl.sv
/*
 * Interrupt controller: pending flags, enable registers, priority select,
 * the forced-call sequence and the global enable of the CPU core.
 * Assumes the CPU reports instruction boundaries and the EI, DI and ISR_RETURN_OP
 * operations as one-cycle pulses on this clock, and advances only while
 * I_CE is high. USB SE0 and GPIO come from pins; other events are on-clock.
 * I_CE low also stalls the bus handshakes, so a master keeps it high then.
 */
// Function
// - Global enable register: bits 0-3,5,6 enable reset, timers, hub, GPIO, I2C.
// - Endpoint enable register: A0-A2 in bits 0-2, B0-B1 in bits 3-4.
// - Any reset clears every implemented enable bit of both registers.
// - Each source has a pending flag held until serviced or reset.
// - A pending source requests only while its enable bit is one.
// - Highest enabled pending request is taken only at an instruction boundary.
// - Acknowledge clears global enable, clears that pending flag, forces a call.
// - The forced call pushes program counter, carry and zero flags.
// - Return from interrupt restores PC and flags and sets global enable.
// - Enable and disable operations change only the global enable bit.
// - Global enable is readable as status register bit 2.
// - Pending requests are visible in status bit 7 while globally disabled.
// - Lower vector number wins; USB reset highest, I2C lowest.
// - Reset starts at 0x0000; vectors two bytes apart from 0x0002 to 0x0018.
// - Vectors 2-12: timers, endpoints A0-B1, hub, DAC, GPIO, I2C.
// - Latency is remaining instruction cycles plus 10 call plus 5 jump.
// - Timer sources fire every 128 us and every 1.024 ms.
// - GPIO fires on a pin edge toward its programmed polarity.
// - Hub fires on status change; nesting allowed once firmware re-enables.
// - Status pending flag is the OR of all pending flags, enabled or not; it clears once no flag remains pending.
// - Writes to the global enable view bit have no effect.
// - USB reset event is raised when the SE0 condition ends.
`timescale 1ns/1ps
`default_nettype none

module mic_irq_ctrl
    import mic_pkg::*;
#(
    parameter int P_T128_CYC = T128_CYC,                // 128 us timer period in clocks.
    parameter int P_T1MS_CYC = T1MS_CYC                 // 1.024 ms timer period in clocks.
)
(
    input  wire logic               I_CLK,              // 200 MHz clock.
    input  wire logic               I_RST_N,            // Asynchronous reset, active low.
    input  wire logic               I_CE,               // Clock enable; low freezes all state.
    input  wire mic_axi_req_t       I_AXI,              // AXI4-Lite request channels.
    output var mic_axi_rsp_t        O_AXI,              // AXI4-Lite response channels.
    input  wire logic               I_USB_SE0,          // Upstream SE0 pin level.
    input  wire logic [GPIO_N-1:0]  I_GPIO,             // GPIO pin levels.
    input  wire logic [4:0]         I_EP_EVT,           // Endpoint events A0,A1,A2,B0,B1.
    input  wire logic               I_HUB_EVT,          // Hub status change pulse.
    input  wire logic               I_DAC_EVT,          // DAC event pulse.
    input  wire logic               I_I2C_EVT,          // I2C unit event pulse.
    input  wire logic               I_INSTR_DONE,       // CPU instruction boundary.
    input  wire logic               I_OP_EI,            // Unmask-all operation executed.
    input  wire logic               I_OP_DI,            // Mask-all operation executed.
    input  wire logic               I_OP_ISR_RETURN_OP,          // Return-from-interrupt executed.
    output logic                    O_GIE,              // CPU global interrupt enable.
    output logic                    O_HOLD,             // CPU held for call and jump.
    output logic                    O_PUSH,             // Push PC, carry and zero flags.
    output logic                    O_RESTORE,          // Pop PC, carry and zero flags.
    output logic [15:0]             O_VECTOR            // Vector address of the call.
);

    mic_state_t            r;
    mic_state_t            n;
    logic [NSRC-1:0]       ev;
    logic [NSRC-1:0]       en_vec;
    logic [NSRC-1:0]       req;
    logic [NSRC-1:0]       clr;
    logic [SRC_W-1:0]      sel;
    logic                  ack_fire;
    logic                  gpio_evt;
    logic                  wr_fire;
    logic [7:0]            wr_idx;
    logic [7:0]            rd_idx;

    // Lowest-numbered request wins, so the scan runs downward.
    function automatic logic [SRC_W-1:0] pick(input logic [NSRC-1:0] v);
        logic [SRC_W-1:0] k;
        k = '0;
        for (int i = NSRC - 1; i >= 0; i--)
        begin
            if (v[i])
            begin
                k = SRC_W'(i);
            end
        end
        return k;
    endfunction

    // Register read mux; unlisted bits read as zero.
    function automatic logic [31:0] rd_val(input mic_state_t s, input logic [7:0] idx);
        logic [31:0] v;
        v = '0;
        unique case (idx)
            IDX_GIE_EN:   v[7:0] = s.gie_en;
            IDX_EP_EN:    v[7:0] = s.ep_en;
            IDX_PEND:     v[NSRC-1:0] = s.pend;
            IDX_GPIO_POL:
            begin
                v[GPIO_N-1:0] = s.gpio_pol;
                v[DAC_EN_BIT] = s.dac_en;
            end
            IDX_PSC:
            begin
                v[PSC_PEND_BIT] = |s.pend;
                v[PSC_GIE_BIT]  = s.gie;
            end
            default:      v = '0;
        endcase
        return v;
    endfunction

    function automatic logic addr_ok(input logic [ADDR_W-1:0] a);
        logic [7:0] i;
        i = a[9:2];
        return (a[ADDR_W-1:10] == '0) && (i == IDX_GIE_EN || i == IDX_EP_EN ||
               i == IDX_PEND || i == IDX_GPIO_POL || i == IDX_PSC);
    endfunction

    // Event sources: SE0 end, pin edges toward polarity, and the two timers.
    always_comb
    begin
        gpio_evt = |((r.gpio_s2 ^ r.gpio_d) & ~(r.gpio_s2 ^ r.gpio_pol));
        ev       = {I_I2C_EVT, gpio_evt, I_DAC_EVT, I_HUB_EVT, I_EP_EVT,
                    (r.t1ms == TMR_W'(P_T1MS_CYC - 1)),
                    (r.t128 == TMR_W'(P_T128_CYC - 1)),
                    (r.se0_d & ~r.se0_s2)};
        en_vec   = {r.gie_en[6], r.gie_en[5], r.dac_en, r.gie_en[3],
                    r.ep_en[4:0], r.gie_en[2:0]};
        req      = r.pend & en_vec;
        sel      = pick(req);
        ack_fire = (r.seq == SEQ_IDLE) && r.gie && (|req) && I_INSTR_DONE;
        clr      = ack_fire ? (NSRC'(1) << sel) : '0;
        wr_fire  = r.aw_v && r.w_v && !r.axi.bvalid;
        wr_idx   = r.aw_a[9:2];
        rd_idx   = I_AXI.araddr[9:2];
    end

    // Next-state logic for the whole block.
    always_comb
    begin
        n         = r;
        n.push    = 1'b0;
        n.restore = 1'b0;

        // Two-flop synchronisers for the pins, then one delay for edges.
        n.se0_s1  = I_USB_SE0;
        n.se0_s2  = r.se0_s1;
        n.se0_d   = r.se0_s2;
        n.gpio_s1 = I_GPIO;
        n.gpio_s2 = r.gpio_s1;
        n.gpio_d  = r.gpio_s2;

        // Free-running timers; enable gates the request, not the count.
        // That saves a restart path, but the first event after an enable may come early.
        n.t128 = (r.t128 == TMR_W'(P_T128_CYC - 1)) ? '0 : r.t128 + 1'b1;
        n.t1ms = (r.t1ms == TMR_W'(P_T1MS_CYC - 1)) ? '0 : r.t1ms + 1'b1;

        // Set wins over clear, and a repeat merges into the held flag.
        n.pend = (r.pend & ~clr) | ev;

        // Global enable: DI and EI touch nothing else; ISR_RETURN_OP also pulses restore.
        if (I_OP_DI)
        begin
            n.gie = 1'b0;
        end
        if (I_OP_EI)
        begin
            n.gie = 1'b1;
        end
        if (I_OP_ISR_RETURN_OP)
        begin
            n.gie     = 1'b1;
            n.restore = 1'b1;
        end

        // Acknowledge sequence: call phase, then the vector-table jump.
        unique case (r.seq)
            SEQ_IDLE:
            begin
                if (ack_fire)
                begin
                    n.gie  = 1'b0;
                    n.push = 1'b1;
                    n.hold = 1'b1;
                    n.vec  = VEC_BASE + {11'h000, sel, 1'b0};
                    n.cnt  = CALL_CYC - 4'h1;
                    n.seq  = SEQ_CALL;
                end
            end
            SEQ_CALL:
            begin
                n.cnt = r.cnt - 4'h1;
                if (r.cnt == 4'h0)
                begin
                    n.cnt = JMP_CYC - 4'h1;
                    n.seq = SEQ_JUMP;
                end
            end
            SEQ_JUMP:
            begin
                n.cnt = r.cnt - 4'h1;
                if (r.cnt == 4'h0)
                begin
                    n.hold = 1'b0;
                    n.seq  = SEQ_IDLE;
                end
            end
        endcase

        // Write address and data are taken in either order.
        if (I_AXI.awvalid && r.axi.awready)
        begin
            n.aw_v = 1'b1;
            n.aw_a = I_AXI.awaddr;
        end
        if (I_AXI.wvalid && r.axi.wready)
        begin
            n.w_v = 1'b1;
            n.w_d = I_AXI.wdata;
            n.w_s = I_AXI.wstrb;
        end
        if (r.axi.bvalid && I_AXI.bready)
        begin
            n.axi.bvalid = 1'b0;
        end
        if (wr_fire)
        begin
            n.aw_v       = 1'b0;
            n.w_v        = 1'b0;
            n.axi.bvalid = 1'b1;
            n.axi.bresp  = addr_ok(r.aw_a) ? RESP_OKAY : RESP_DECERR;
            if (addr_ok(r.aw_a) && r.w_s[0])
            begin
                // The status register view of the enable is read-only.
                unique case (wr_idx)
                    IDX_GIE_EN:   n.gie_en = r.w_d[7:0] & GIE_EN_MASK;
                    IDX_EP_EN:    n.ep_en  = r.w_d[7:0] & EP_EN_MASK;
                    default:      n.gie_en = n.gie_en;
                endcase
            end
            if (addr_ok(r.aw_a) && wr_idx == IDX_GPIO_POL)
            begin
                if (r.w_s[0])
                begin
                    n.gpio_pol[7:0] = r.w_d[7:0];
                end
                if (r.w_s[1])
                begin
                    n.gpio_pol[GPIO_N-1:8] = r.w_d[GPIO_N-1:8];
                end
                if (r.w_s[2])
                begin
                    n.dac_en = r.w_d[DAC_EN_BIT];
                end
            end
        end

        // Read answers one cycle after the address is taken.
        if (r.axi.rvalid && I_AXI.rready)
        begin
            n.axi.rvalid = 1'b0;
        end
        if (I_AXI.arvalid && r.axi.arready)
        begin
            n.axi.rvalid = 1'b1;
            // An unmapped word reads as zero, whatever its index bits hold.
            n.axi.rdata  = addr_ok(I_AXI.araddr) ? rd_val(r, rd_idx) : '0;
            n.axi.rresp  = addr_ok(I_AXI.araddr) ? RESP_OKAY : RESP_DECERR;
        end

        // Ready flags are registered so that every output is a flop.
        n.axi.awready = !n.aw_v;
        n.axi.wready  = !n.w_v;
        n.axi.arready = !n.axi.rvalid;
    end

    // State register; reset clears every enable and flag but sets the three ready flags.
    always_ff @(posedge I_CLK or negedge I_RST_N)
    begin
        if (!I_RST_N)
        begin
            r             <= '0;
            r.seq         <= SEQ_IDLE;
            r.gie_en      <= EN_RESET;
            r.ep_en       <= EN_RESET;
            r.vec         <= RESET_PC;
            r.axi.awready <= 1'b1;
            r.axi.wready  <= 1'b1;
            r.axi.arready <= 1'b1;
        end
        else if (I_CE)
        begin
            r <= n;
        end
    end

    assign O_AXI     = r.axi;
    assign O_GIE     = r.gie;
    assign O_HOLD    = r.hold;
    assign O_PUSH    = r.push;
    assign O_RESTORE = r.restore;
    assign O_VECTOR  = r.vec;

    // Helper: counts enabled cycles of one hold period.
    logic [4:0] hold_len;
    always_ff @(posedge I_CLK or negedge I_RST_N)
    begin
        if (!I_RST_N)
        begin
            hold_len <= '0;
        end
        else if (I_CE)
        begin
            hold_len <= r.hold ? hold_len + 5'h01 : 5'h00;
        end
    end

    // Every property samples on the clock and is dropped while reset is low.
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!I_RST_N);

    a_gie_reserved: assert property ((r.gie_en & ~GIE_EN_MASK) == '0)
        else $error("reserved global enable bit set");
    a_ep_reserved: assert property ((r.ep_en & ~EP_EN_MASK) == '0)
        else $error("reserved endpoint enable bit set");
    a_pend_held: assert property ((I_CE && (|(r.pend & ~clr))) |=>
        ((r.pend & $past(r.pend & ~clr)) == $past(r.pend & ~clr)))
        else $error("pending flag lost without acknowledge");
    a_ack_enabled: assert property (ack_fire |-> en_vec[sel] && r.pend[sel]
        && ((req & ((NSRC'(1) << sel) - NSRC'(1))) == '0))
        else $error("acknowledge picked a disabled or lower source");
    a_ack_entry: assert property ((I_CE && ack_fire) |=> r.hold && r.push
        && !r.gie && (!r.pend[$past(sel)] || $past(ev[sel])))
        else $error("acknowledge entry wrong");
    a_call_len: assert property ((I_CE && r.hold && r.seq == SEQ_JUMP
        && r.cnt == 4'h0) |-> hold_len == 5'(CALL_CYC + JMP_CYC - 4'h1))
        else $error("call plus jump length wrong");
    a_vec_range: assert property (r.hold |-> r.vec[0] == 1'b0
        && r.vec >= VEC_BASE && r.vec <= VEC_BASE + 16'(2 * (NSRC - 1)))
        else $error("vector out of table");
    a_isr_return_op_gie: assert property ((I_CE && I_OP_ISR_RETURN_OP && !ack_fire) |=>
        r.gie && r.restore)
        else $error("return did not restore enable");
    a_set_wins: assert property ((I_CE && (|ev)) |=>
        (($past(ev) & ~r.pend) == '0))
        else $error("event lost on clear");
    a_di_only: assert property ((I_CE && I_OP_DI && !I_OP_EI && !I_OP_ISR_RETURN_OP
        && !wr_fire) |=> !r.gie && $stable(r.gie_en) && $stable(r.ep_en))
        else $error("disable touched more than the enable");
    a_push_once: assert property ((I_CE && r.push) |=> !r.push)
        else $error("push pulse longer than one cycle");
    a_ce_freeze: assert property (!I_CE |=> (r == $past(r)))
        else $error("state moved while the clock enable was low");
    a_psc_view: assert property ((I_CE && I_AXI.arvalid && r.axi.arready
        && addr_ok(I_AXI.araddr) && rd_idx == IDX_PSC)
        |=> r.axi.rdata[PSC_GIE_BIT] == $past(r.gie)
        && r.axi.rdata[PSC_PEND_BIT] == $past(|r.pend))
        else $error("status view of enable or pending wrong");

    // Scenarios the bench is meant to reach.
    c_ack: cover property (I_CE && ack_fire);
    c_nest: cover property (r.hold ##1 I_OP_EI [*1] ##[1:40] ack_fire);
    c_set_clr: cover property (ack_fire && ev[sel]);
    c_masked_pend: cover property (!r.gie && (|r.pend));
    c_stall: cover property (!I_CE && r.hold);

endmodule

`default_nettype wire

// File: rtl/mic_pkg.sv
/*
 * Shared constants and types for the microcontroller interrupt controller.
 * Assumes a single 200 MHz clock and an AXI4-Lite master with 32-bit data.
 */
package mic_pkg;

    // Register indices; the byte address on the bus is four times the index.
    localparam logic [7:0]  IDX_GIE_EN   = 8'h20;
    localparam logic [7:0]  IDX_EP_EN    = 8'h21;
    localparam logic [7:0]  IDX_PEND     = 8'h30;
    localparam logic [7:0]  IDX_GPIO_POL = 8'h31;
    localparam logic [7:0]  IDX_PSC      = 8'hFF;
    localparam int          ADDR_W       = 12;

    // Implemented bits of the two enable registers; reset value of both.
    localparam logic [7:0]  GIE_EN_MASK  = 8'h6F;
    localparam logic [7:0]  EP_EN_MASK   = 8'h1F;
    localparam logic [7:0]  EN_RESET     = 8'h00;
    localparam int          PSC_PEND_BIT = 7;
    localparam int          PSC_GIE_BIT  = 2;
    localparam int          DAC_EN_BIT   = 16;

    // Source numbering: index k is vector k+1, lower index wins.
    localparam int          NSRC         = 12;
    localparam int          GPIO_N       = 11;
    localparam int          SRC_W        = 4;

    // Acknowledge timing in clock-enabled cycles, and vector layout.
    localparam logic [3:0]  CALL_CYC     = 4'hA;
    localparam logic [3:0]  JMP_CYC      = 4'h5;
    localparam logic [15:0] RESET_PC     = 16'h0000;
    localparam logic [15:0] VEC_BASE     = 16'h0002;

    // Periodic timers: periods in microseconds (1.024 ms written as 1024 us).
    localparam int          CLK_MHZ      = 200;
    localparam int          T128_US      = 128;
    localparam int          T1MS_US      = 1024;
    localparam int          T128_CYC     = T128_US * CLK_MHZ;
    localparam int          T1MS_CYC     = T1MS_US * CLK_MHZ;
    localparam int          TMR_W        = 18;

    localparam logic [1:0]  RESP_OKAY    = 2'h0;
    localparam logic [1:0]  RESP_DECERR  = 2'h3;

    typedef enum logic [1:0] {SEQ_IDLE, SEQ_CALL, SEQ_JUMP} mic_seq_t;

    typedef struct packed {
        logic                awvalid;
        logic [ADDR_W-1:0]   awaddr;
        logic                wvalid;
        logic [31:0]         wdata;
        logic [3:0]          wstrb;
        logic                bready;
        logic                arvalid;
        logic [ADDR_W-1:0]   araddr;
        logic                rready;
    } mic_axi_req_t;

    typedef struct packed {
        logic                awready;
        logic                wready;
        logic                bvalid;
        logic [1:0]          bresp;
        logic                arready;
        logic                rvalid;
        logic [31:0]         rdata;
        logic [1:0]          rresp;
    } mic_axi_rsp_t;

    typedef struct packed {
        mic_seq_t            seq;
        logic [3:0]          cnt;
        logic                gie;
        logic [NSRC-1:0]     pend;
        logic [7:0]          gie_en;
        logic [7:0]          ep_en;
        logic [GPIO_N-1:0]   gpio_pol;
        logic                dac_en;
        logic [15:0]         vec;
        logic                push;
        logic                restore;
        logic                hold;
        logic                se0_s1;
        logic                se0_s2;
        logic                se0_d;
        logic [GPIO_N-1:0]   gpio_s1;
        logic [GPIO_N-1:0]   gpio_s2;
        logic [GPIO_N-1:0]   gpio_d;
        logic [TMR_W-1:0]    t128;
        logic [TMR_W-1:0]    t1ms;
        logic                aw_v;
        logic [ADDR_W-1:0]   aw_a;
        logic                w_v;
        logic [31:0]         w_d;
        logic [3:0]          w_s;
        mic_axi_rsp_t        axi;
    } mic_state_t;

endpackage

// File: dv/mic_cpu_model.sv
/* CPU core stand-in: three-cycle instructions and operation pulses.
   Assumes the controller stalls it through O_HOLD during a forced call. */
`timescale 1ns/1ps
`default_nettype none
module mic_cpu_model
    import mic_pkg::*;
(
    input  wire logic i_clk,     // Clock.
    input  wire logic i_rst_n,   // Reset, active low.
    input  wire logic i_hold,    // Forced call running.
    input  wire logic i_push,    // Push pulse.
    input  wire logic i_restore, // Pop pulse.
    output logic      o_done,    // Instruction boundary.
    output logic      o_ei,      // Unmask-all pulse.
    output logic      o_di,      // Mask-all pulse.
    output logic      o_isr_return_op     // Return pulse.
);
    logic [1:0] phase_r;
    int         depth;
    // Stack depth lets the bench see that pushes and pops pair up.
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            phase_r <= 2'h0;
            depth   <= 0;
        end
        else
        begin
            if (!i_hold) phase_r <= (phase_r == 2'h2) ? 2'h0 : phase_r + 2'h1;
            depth <= depth + int'(i_push) - int'(i_restore);
        end
    end
    // A boundary only between instructions, never inside the forced call.
    assign o_done = (phase_r == 2'h2) && !i_hold;
    initial
    begin
        o_ei   = 1'b0;
        o_di   = 1'b0;
        o_isr_return_op = 1'b0;
    end
    // One operation pulse: 0 unmask, 1 mask, 2 return.
    task automatic op(input int k);
    begin
        @(posedge i_clk);
        o_ei   <= (k == 0);
        o_di   <= (k == 1);
        o_isr_return_op <= (k == 2);
        @(posedge i_clk);
        {o_ei, o_di, o_isr_return_op} <= 3'h0;
    end
    endtask
endmodule
`default_nettype wire

// File: dv/mic_irq_ctrl_tb_top.sv
/* Self-checking bench for the interrupt controller over AXI4-Lite.
   Assumes short timer periods; the CPU model drives boundaries and ops. */
`timescale 1ns/1ps
`default_nettype none
module mic_irq_ctrl_tb_top;
    import mic_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0, se0 = 1'b0, hub = 1'b0, dac = 1'b0, i2c = 1'b0;
    logic ce = 1'b1;
    logic [3:0] wst = 4'hF;
    logic [GPIO_N-1:0] gpio = '0;
    logic [4:0] ep = '0;
    logic gie, hold, push, rest, done, ei, di, isr_return_op;
    logic [15:0] vec;
    mic_axi_req_t req = '0;
    mic_axi_rsp_t rsp;
    int fails = 0, num_checks = 0;
    always #2.5 clk = ~clk;
    mic_irq_ctrl #(.P_T128_CYC(20), .P_T1MS_CYC(50)) mic_irq_ctrl_inst (.I_CLK(clk),
        .I_RST_N(rst_n), .I_CE(ce), .I_AXI(req), .O_AXI(rsp), .I_USB_SE0(se0),
        .I_GPIO(gpio), .I_EP_EVT(ep), .I_HUB_EVT(hub), .I_DAC_EVT(dac), .I_I2C_EVT(i2c),
        .I_INSTR_DONE(done), .I_OP_EI(ei), .I_OP_DI(di), .I_OP_ISR_RETURN_OP(isr_return_op), .O_GIE(gie),
        .O_HOLD(hold), .O_PUSH(push), .O_RESTORE(rest), .O_VECTOR(vec));
    mic_cpu_model mic_cpu_model_inst (.i_clk(clk), .i_rst_n(rst_n), .i_hold(hold),
        .i_push(push), .i_restore(rest), .o_done(done), .o_ei(ei), .o_di(di), .o_isr_return_op(isr_return_op));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    begin
        num_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
        end
    end
    endtask
    // Both write channels offered together; bready held until the response.
    task automatic wr(input logic [11:0] a, input logic [31:0] dat, input logic [1:0] er);
    begin
        @(posedge clk);
        req.awvalid <= 1'b1; req.awaddr <= a; req.wvalid <= 1'b1;
        req.wdata <= dat; req.wstrb <= wst; req.bready <= 1'b1;
        do
        begin
            @(posedge clk);
            if (rsp.awready) req.awvalid <= 1'b0;
            if (rsp.wready) req.wvalid <= 1'b0;
        end while (!rsp.bvalid);
        req.bready <= 1'b0;
        chk(rsp.bresp, er, "bresp");
    end
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] mk, input logic [31:0] ex,
                      input logic [1:0] er);
    begin
        @(posedge clk);
        req.arvalid <= 1'b1; req.araddr <= a; req.rready <= 1'b1;
        do
        begin
            @(posedge clk);
            if (rsp.arready) req.arvalid <= 1'b0;
        end while (!rsp.rvalid);
        req.rready <= 1'b0;
        chk(rsp.rdata & mk, ex, "rdata");
        chk(rsp.rresp, er, "rresp");
    end
    endtask
    // Waits for an acknowledge, then times the forced call; stall drops I_CE mid-call.
    task automatic serve(input logic [15:0] v, input int stall);
        int n;
    begin
        n = 0;
        while (hold !== 1'b1 && n < 100)
        begin
            @(posedge clk); #1;
            n++;
        end
        chk(vec, v, "vector");
        chk({gie, push}, 2'h1, "gie off, push on");
        n = 0;
        while (hold === 1'b1 && n < 40)
        begin
            n++;
            @(posedge clk);
            ce <= !(n >= 2 && n < 2 + stall);
            #1;
        end
        chk(n, 15 + stall, "hold length");
        mic_cpu_model_inst.op(2);
        #1 chk({gie, rest}, 2'h3, "return");
    end
    endtask
    task automatic give_verdict();
    begin
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    end
    endtask
    initial
    begin
        #100us;
        fails++;
        give_verdict();
    end
    initial
    begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        rd(12'h080, 32'hFF, 32'h0, RESP_OKAY);
        rd(12'h084, 32'hFF, 32'h0, RESP_OKAY);
        wr(12'h080, 32'hFF, RESP_OKAY);
        rd(12'h080, 32'hFF, 32'h6F, RESP_OKAY);
        wr(12'h084, 32'hFF, RESP_OKAY);
        rd(12'h084, 32'hFF, 32'h1F, RESP_OKAY);
        wr(12'h100, 32'h1, RESP_DECERR);
        rd(12'h100, 32'hFFFFFFFF, 32'h0, RESP_DECERR);
        wr(12'h080, 32'h69, RESP_OKAY);
        wr(12'h0C4, 32'h1, RESP_OKAY);
        // Several sources at once, hub twice, pins toggled.
        @(posedge clk);
        {ep, hub, dac, i2c, se0, gpio[0]} <= {5'h1, 5'h1F};
        @(posedge clk);
        {ep, hub, dac, i2c} <= '0;
        @(posedge clk);
        {hub, se0} <= 2'h2;
        @(posedge clk);
        hub <= 1'b0;
        repeat (3) @(posedge clk);
        rd(12'h0C0, 32'hFF9, 32'hF09, RESP_OKAY);
        rd(12'h3FC, 32'h84, 32'h80, RESP_OKAY);
        wr(12'h3FC, 32'h04, RESP_OKAY);
        rd(12'h3FC, 32'h04, 32'h0, RESP_OKAY);
        mic_cpu_model_inst.op(0);
        serve(16'h0002, 0);
        serve(16'h0008, 0);
        serve(16'h0012, 0);
        serve(16'h0016, 0);
        serve(16'h0018, 0);
        repeat (30) @(posedge clk);
        #1 chk(hold, 1'b0, "no further ack");
        chk(mic_cpu_model_inst.depth, 0, "stack balance");
        rd(12'h0C0, 32'hFF9, 32'h200, RESP_OKAY);
        mic_cpu_model_inst.op(1);
        rd(12'h3FC, 32'h84, 32'h80, RESP_OKAY);
        rd(12'h080, 32'hFF, 32'h69, RESP_OKAY);
        // A write without its low strobe leaves the 8-bit register alone.
        wst = 4'hE;
        wr(12'h084, 32'h00, RESP_OKAY);
        wst = 4'hF;
        rd(12'h084, 32'hFF, 32'h1F, RESP_OKAY);
        // Falling polarity, DAC enable and the remaining endpoints.
        wr(12'h0C4, 32'h10000, RESP_OKAY);
        {ep, gpio[0]} <= 6'h3C;
        @(posedge clk);
        ep <= '0;
        mic_cpu_model_inst.op(0);
        serve(16'h000A, 0);
        serve(16'h000C, 0);
        serve(16'h000E, 0);
        serve(16'h0010, 0);
        serve(16'h0014, 3);
        serve(16'h0016, 0);
        mic_cpu_model_inst.op(1);
        wr(12'h080, 32'h02, RESP_OKAY);
        mic_cpu_model_inst.op(0);
        serve(16'h0004, 0);
        // A second reset in mid-run clears the enables and the vector again.
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        #1 chk({vec, gie, hold}, 18'h0, "reset state");
        rd(12'h080, 32'hFF, 32'h0, RESP_OKAY);
        rd(12'h084, 32'hFF, 32'h0, RESP_OKAY);
        give_verdict();
    end
endmodule
`default_nettype wire
